//--- core/srm_core.sv
// Behaviour
// - dispatch mask seeds execution mask; masked channels unwritten
// - in vec4 and paired modes, disabled destination components keep old contents
// - paired mode sources need only 16-byte alignment
// - zero vertical stride rereads same elements per row
// - <0;1,0> region replicates one element everywhere
// - sixteen channels: operand spans two consecutive registers
// - dispatch mask seen as four 4-bit groups
// - compressed op runs two halves, next register
// - no indirect addressing in sixteen channel mode
// - operand file: general, architecture or immediate; architecture operands are refused here
// - each thread context private to that thread
// - one memory split, 128 registers per thread
// - byte-granular region access with byte write enables; here region offsets must be dword aligned
// - source region within two adjacent registers
// - destination region within one register
// - indirect address is index register plus offset
// - out-of-range access result is unpredictable; here it is refused: reads return zero, writes are dropped
// - payload loaded at dispatch; rest uninitialised
// - each register 256 bits, eight dwords
module srm_core #(
    parameter int NUM_THREADS = 4
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic DISPATCH_VALID,
    input wire logic [$clog2(NUM_THREADS)-1:0] DISPATCH_THREAD,
    input wire logic [15:0] DISPATCH_MASK,
    input wire logic LOAD_VALID,
    input wire logic [$clog2(NUM_THREADS)-1:0] LOAD_THREAD,
    input wire logic [6:0] LOAD_REG,
    input wire logic [31:0] LOAD_BYTE_EN,
    input wire logic [255:0] LOAD_DATA,
    input wire logic INDEX_WRITE,
    input wire logic [$clog2(NUM_THREADS)-1:0] INDEX_THREAD,
    input wire logic [2:0] INDEX_SEL,
    input wire logic [11:0] INDEX_VALUE,
    input wire logic SRC_VALID,
    input wire logic [$clog2(NUM_THREADS)-1:0] SRC_THREAD,
    input wire logic [1:0] SRC_MODE,
    input wire logic SRC_SECOND_HALF,
    input wire logic [1:0] SRC_FILE,
    input wire logic SRC_INDIRECT,
    input wire logic [2:0] SRC_INDEX_SEL,
    input wire logic [11:0] SRC_ADDR,
    input wire logic [5:0] SRC_VSTRIDE,
    input wire logic [2:0] SRC_WIDTH_LOG2,
    input wire logic [2:0] SRC_HSTRIDE,
    input wire logic [31:0] SRC_IMM,
    output logic SRC_DONE,
    output logic SRC_ERROR,
    output logic [255:0] SRC_DATA,
    input wire logic DST_VALID,
    input wire logic [$clog2(NUM_THREADS)-1:0] DST_THREAD,
    input wire logic [1:0] DST_MODE,
    input wire logic DST_SECOND_HALF,
    input wire logic DST_INDIRECT,
    input wire logic [2:0] DST_INDEX_SEL,
    input wire logic [11:0] DST_ADDR,
    input wire logic [2:0] DST_HSTRIDE,
    input wire logic [3:0] DST_COMP_MASK,
    input wire logic [255:0] DST_DATA,
    output logic DST_DONE,
    output logic DST_ERROR,
    input wire logic [$clog2(NUM_THREADS)-1:0] STATUS_THREAD,
    output logic [15:0] STATUS_MASK,
    output logic [3:0] STATUS_GROUPS
);
    localparam int TW = $clog2(NUM_THREADS);

    // thread field widths assume a power of two of at least two
    if (NUM_THREADS < 2 || (1 << TW) != NUM_THREADS)
    begin : g_bad_threads
        $error("NUM_THREADS must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [NUM_THREADS-1:0][15:0] exec_mask;
        logic [255:0] src_data;
        logic src_done;
        logic src_err;
        logic dst_done;
        logic dst_err;
    } srm_state_t;

    srm_state_t state_ff;
    srm_state_t nxt_state;

    // 256-bit registers
    // one array for all threads; {thread, reg} keeps contexts apart
    logic [255:0] grf_mem [NUM_THREADS*srm_pkg::REGS_PER_THREAD];
    logic [11:0] idx_mem [NUM_THREADS*srm_pkg::INDEX_ELEMS];

    logic [11:0] src_idx_val;
    logic [11:0] src_byte_addr;
    logic [6:0] src_reg;
    logic [4:0] src_sub;
    logic [511:0] src_window;
    logic [3:0] src_elem_base;
    logic [7:0][31:0] elem_val;
    logic [7:0] elem_ok;
    logic [3:0] src_count;
    logic src_err_c;
    logic [255:0] src_data_c;

    logic [11:0] dst_idx_val;
    logic [11:0] dst_byte_addr;
    logic [TW+6:0] dst_row;
    logic [4:0] dst_sub;
    logic [7:0] dst_chan;
    logic [3:0] dst_count;
    logic dst_err_c;
    logic dst_write;
    logic [31:0] wr_be;
    logic [255:0] wr_data;

    // index plus offset
    // indirect source address; wraps inside the thread's own space
    always_comb
    begin
        src_idx_val = idx_mem[{SRC_THREAD, SRC_INDEX_SEL}];
        src_byte_addr = SRC_INDIRECT ? src_idx_val + SRC_ADDR : SRC_ADDR;
        src_reg = src_byte_addr[11:5];
        src_sub = src_byte_addr[4:0];
    end

    assign src_window = {grf_mem[{SRC_THREAD, src_reg + 7'h01}], grf_mem[{SRC_THREAD, src_reg}]};

    // second half elements
    // compressed second half walks on to elements 15:8 of the region
    assign src_elem_base = (SRC_MODE == srm_pkg::MODE_SIXTEEN && SRC_SECOND_HALF) ? srm_pkg::SECOND_HALF_ELEM : 4'h0;
    assign src_count = (SRC_MODE == srm_pkg::MODE_VEC4) ? 4'h4 : 4'h8;

    // pair of registers
    // zero strides fall out of the offset math, no special case needed
    for (genvar i = 0; i < srm_pkg::HALF_CHANNELS; i++)
    begin : g_elem
        srm_elem u_elem (
            .ELEM(src_elem_base + 4'(i)),
            .SUBREG(src_sub),
            .VSTRIDE(SRC_VSTRIDE),
            .WIDTH_LOG2(SRC_WIDTH_LOG2),
            .HSTRIDE(SRC_HSTRIDE),
            .WINDOW(src_window),
            .VALUE(elem_val[i]),
            .IN_RANGE(elem_ok[i])
        );
    end

    // three operand files
    // architecture registers live elsewhere, so they are refused here
    always_comb
    begin
        src_err_c = 1'b0;
        src_data_c = '0;
        unique case (SRC_FILE)
            srm_pkg::FILE_IMM:
            begin
                src_data_c = {8{SRC_IMM}};
            end
            srm_pkg::FILE_GRF:
            begin
                if (SRC_INDIRECT && SRC_MODE == srm_pkg::MODE_SIXTEEN)
                    src_err_c = 1'b1;
                if (src_sub[1:0] != 2'h0)
                    src_err_c = 1'b1;
                if (SRC_MODE == srm_pkg::MODE_PAIRED && src_sub[3:0] != 4'h0)
                    src_err_c = 1'b1;
                for (int i = 0; i < srm_pkg::HALF_CHANNELS; i++)
                begin
                    if (4'(i) < src_count)
                    begin
                        if (!elem_ok[i])
                            src_err_c = 1'b1;
                        src_data_c[32*i +: 32] = elem_val[i];
                    end
                end
            end
            default:
            begin
                src_err_c = 1'b1;
            end
        endcase
    end

    // destination address; second compressed half targets the next register
    always_comb
    begin
        dst_idx_val = idx_mem[{DST_THREAD, DST_INDEX_SEL}];
        dst_byte_addr = DST_INDIRECT ? dst_idx_val + DST_ADDR : DST_ADDR;
        if (DST_MODE == srm_pkg::MODE_SIXTEEN && DST_SECOND_HALF)
            dst_byte_addr = dst_byte_addr + srm_pkg::NEXT_REG_BYTES;
        dst_row = {DST_THREAD, dst_byte_addr[11:5]};
        dst_sub = dst_byte_addr[4:0];
        dst_count = (DST_MODE == srm_pkg::MODE_VEC4) ? 4'h4 : 4'h8;
    end

    assign dst_chan = DST_SECOND_HALF ? state_ff.exec_mask[DST_THREAD][15:8] : state_ff.exec_mask[DST_THREAD][7:0];

    // byte enables and data steered into place by the destination stride
    always_comb
    begin
        logic [7:0] off;
        logic comp_ok;
        off = 8'h00;
        comp_ok = 1'b1;
        dst_err_c = 1'b0;
        wr_be = '0;
        wr_data = '0;
        if (DST_INDIRECT && DST_MODE == srm_pkg::MODE_SIXTEEN)
            dst_err_c = 1'b1;
        if (dst_sub[1:0] != 2'h0)
            dst_err_c = 1'b1;
        for (int i = 0; i < srm_pkg::HALF_CHANNELS; i++)
        begin
            off = 8'(dst_sub) + 8'(4 * i * int'(DST_HSTRIDE));
            comp_ok = (DST_MODE == srm_pkg::MODE_VEC4 || DST_MODE == srm_pkg::MODE_PAIRED) ? DST_COMP_MASK[i % 4] : 1'b1;
            if (4'(i) < dst_count)
            begin
                if (off > 8'(srm_pkg::DST_LAST_BYTE))
                    dst_err_c = 1'b1;
                else if (dst_chan[i] && comp_ok)
                begin
                    for (int k = 0; k < srm_pkg::ELEM_BYTES; k++)
                    begin
                        wr_be[int'(off[4:0]) + k] = 1'b1;
                        wr_data[8*(int'(off[4:0]) + k) +: 8] = DST_DATA[32*i + 8*k +: 8];
                    end
                end
            end
        end
    end

    assign dst_write = DST_VALID && !dst_err_c;

    // payload load port
    // memories hold no reset: unloaded registers read whatever is there
    always_ff @(posedge CLOCK)
    begin
        if (LOAD_VALID)
        begin
            for (int b = 0; b < srm_pkg::REG_BYTES; b++)
            begin
                if (LOAD_BYTE_EN[b])
                    grf_mem[{LOAD_THREAD, LOAD_REG}][8*b +: 8] <= LOAD_DATA[8*b +: 8];
            end
        end
        // an instruction write lands after a payload write to the same bytes
        if (dst_write)
        begin
            for (int b = 0; b < srm_pkg::REG_BYTES; b++)
            begin
                if (wr_be[b])
                    grf_mem[dst_row][8*b +: 8] <= wr_data[8*b +: 8];
            end
        end
        if (INDEX_WRITE)
            idx_mem[{INDEX_THREAD, INDEX_SEL}] <= INDEX_VALUE;
    end

    // next state
    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.src_done = SRC_VALID;
        nxt_state.dst_done = DST_VALID;
        nxt_state.dst_err = DST_VALID && dst_err_c;
        if (DISPATCH_VALID)
            nxt_state.exec_mask[DISPATCH_THREAD] = DISPATCH_MASK;
        if (SRC_VALID)
        begin
            nxt_state.src_err = src_err_c;
            nxt_state.src_data = src_err_c ? '0 : src_data_c;
        end
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            state_ff.exec_mask <= {NUM_THREADS{srm_pkg::MASK_RESET}};
            state_ff.src_data <= '0;
            state_ff.src_done <= 1'b0;
            state_ff.src_err <= 1'b0;
            state_ff.dst_done <= 1'b0;
            state_ff.dst_err <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign SRC_DONE = state_ff.src_done;
    assign SRC_ERROR = state_ff.src_err;
    assign SRC_DATA = state_ff.src_data;
    assign DST_DONE = state_ff.dst_done;
    assign DST_ERROR = state_ff.dst_err;
    assign STATUS_MASK = state_ff.exec_mask[STATUS_THREAD];

    // four-bit groups
    // a group shows live when any channel in it is enabled
    for (genvar g = 0; g < srm_pkg::NUM_GROUPS; g++)
    begin : g_group
        assign STATUS_GROUPS[g] = |STATUS_MASK[srm_pkg::GROUP_BITS*g +: srm_pkg::GROUP_BITS];
    end

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    mask_load_a: assert property (DISPATCH_VALID ##1 1 |-> state_ff.exec_mask[$past(DISPATCH_THREAD)] == $past(DISPATCH_MASK))
        else $error("execution mask not taken from dispatch");
    masked_write_a: assert property (DST_VALID && dst_chan == 8'h00 |-> wr_be == 32'h0000_0000)
        else $error("masked channel produced byte enables");
    comp_keep_a: assert property (DST_VALID && DST_MODE == srm_pkg::MODE_PAIRED && DST_COMP_MASK == 4'h0 |-> wr_be == 32'h0000_0000)
        else $error("disabled component written");
    paired_align_a: assert property (SRC_VALID && SRC_FILE == srm_pkg::FILE_GRF && SRC_MODE == srm_pkg::MODE_PAIRED && src_sub[3:0] != 4'h0 |=> SRC_ERROR)
        else $error("paired source misalignment accepted");
    scalar_rep_a: assert property (SRC_VALID && SRC_FILE == srm_pkg::FILE_GRF && !SRC_INDIRECT && SRC_VSTRIDE == 6'h00 && SRC_WIDTH_LOG2 == 3'h0 && SRC_HSTRIDE == 3'h0 && SRC_MODE == srm_pkg::MODE_EIGHT && SRC_ADDR[1:0] == 2'h0 |=> !SRC_ERROR && SRC_DATA[255:32] == {7{SRC_DATA[31:0]}})
        else $error("scalar region not replicated");
    indirect_sixteen_a: assert property ((SRC_VALID && SRC_FILE == srm_pkg::FILE_GRF && SRC_INDIRECT && SRC_MODE == srm_pkg::MODE_SIXTEEN |=> SRC_ERROR) and (DST_VALID && DST_INDIRECT && DST_MODE == srm_pkg::MODE_SIXTEEN |=> DST_ERROR && $past(!dst_write)))
        else $error("sixteen channel indirect access accepted");
    imm_operand_a: assert property (SRC_VALID && SRC_FILE == srm_pkg::FILE_IMM |=> !SRC_ERROR && SRC_DATA == {8{$past(SRC_IMM)}})
        else $error("immediate operand not replicated");
    src_region_a: assert property (SRC_VALID && SRC_FILE == srm_pkg::FILE_GRF && SRC_WIDTH_LOG2 == 3'h0 && SRC_VSTRIDE == 6'h10 |=> SRC_ERROR)
        else $error("source region beyond two registers accepted");
    dst_region_a: assert property (DST_VALID && DST_HSTRIDE == 3'h4 && DST_MODE != srm_pkg::MODE_VEC4 |=> DST_ERROR)
        else $error("destination region beyond one register accepted");
    answer_time_a: assert property (SRC_VALID || DST_VALID |=> (SRC_DONE == $past(SRC_VALID)) && (DST_DONE == $past(DST_VALID)))
        else $error("answer not one cycle after request");

    paired_both_c: cover property (DISPATCH_VALID && DISPATCH_MASK == srm_pkg::MASK_PAIRED_BOTH ##1 DST_VALID && dst_write);
    paired_one_c: cover property (DISPATCH_VALID && DISPATCH_MASK == srm_pkg::MASK_PAIRED_ONE ##1 DST_VALID && dst_write);
    second_half_c: cover property (SRC_VALID && SRC_MODE == srm_pkg::MODE_SIXTEEN && SRC_SECOND_HALF ##1 !SRC_ERROR);
    partial_comp_c: cover property (dst_write && DST_COMP_MASK == 4'h7 && DST_MODE == srm_pkg::MODE_PAIRED);
endmodule

//--- core/srm_elem.sv
// one source element: region position to byte offset inside a two-register window
module srm_elem (
    input wire logic [3:0] ELEM,
    input wire logic [4:0] SUBREG,
    input wire logic [5:0] VSTRIDE,
    input wire logic [2:0] WIDTH_LOG2,
    input wire logic [2:0] HSTRIDE,
    input wire logic [511:0] WINDOW,
    output logic [31:0] VALUE,
    output logic IN_RANGE
);
    logic [3:0] row;
    logic [3:0] col;
    logic [13:0] off;

    // row and column of the element, then byte offset from the window start
    always_comb
    begin
        row = ELEM >> WIDTH_LOG2;
        col = ELEM & 4'((5'h01 << WIDTH_LOG2) - 5'h01);
        off = 14'(SUBREG) + 14'(4 * (int'(row) * int'(VSTRIDE) + int'(col) * int'(HSTRIDE)));
        IN_RANGE = (off <= 14'(srm_pkg::SRC_LAST_BYTE));
        // dword-aligned pick keeps the part-select inside the window
        VALUE = WINDOW[32 * int'(off[5:2]) +: 32];
    end
endmodule

//--- core/srm_pkg.sv
package srm_pkg;
    // register geometry
    localparam int REG_BITS = 256;
    localparam int REG_BYTES = 32;
    localparam int REGS_PER_THREAD = 128;
    localparam int REG_NUM_W = 7;
    localparam int ELEM_BYTES = 4;
    localparam int ELEM_BITS = 32;
    localparam int HALF_CHANNELS = 8;
    localparam int WINDOW_BITS = 512;
    localparam int BYTE_ADDR_W = 12;
    // dispatch mask layout
    localparam int MASK_BITS = 16;
    localparam int GROUP_BITS = 4;
    localparam int NUM_GROUPS = 4;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [15:0] MASK_PAIRED_BOTH = 16'h00FF;
    localparam logic [15:0] MASK_PAIRED_ONE = 16'h000F;
    // index address register
    localparam int INDEX_ELEMS = 8;
    localparam int INDEX_SEL_W = 3;
    // region limits
    localparam int SRC_LAST_BYTE = 60;
    localparam int DST_LAST_BYTE = 28;
    localparam logic [11:0] NEXT_REG_BYTES = 12'h020;
    localparam logic [3:0] SECOND_HALF_ELEM = 4'h8;
    // execution modes
    localparam logic [1:0] MODE_VEC4 = 2'h0;
    localparam logic [1:0] MODE_PAIRED = 2'h1;
    localparam logic [1:0] MODE_EIGHT = 2'h2;
    localparam logic [1:0] MODE_SIXTEEN = 2'h3;
    // operand register-file encodings
    localparam logic [1:0] FILE_ARF = 2'h0;
    localparam logic [1:0] FILE_GRF = 2'h1;
    localparam logic [1:0] FILE_IMM = 2'h3;
endpackage

//--- tb/simd_register_file_masking_tb.sv
module simd_register_file_masking_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLOCK = 1'h0;
    logic RST = 1'h1;
    logic DISPATCH_VALID, LOAD_VALID, INDEX_WRITE, SRC_VALID, SRC_SECOND_HALF, SRC_INDIRECT;
    logic DST_VALID, DST_SECOND_HALF, DST_INDIRECT, SRC_DONE, SRC_ERROR, DST_DONE, DST_ERROR;
    logic [1:0] DISPATCH_THREAD, LOAD_THREAD, INDEX_THREAD, SRC_THREAD, SRC_MODE, SRC_FILE;
    logic [1:0] DST_THREAD, DST_MODE, STATUS_THREAD;
    logic [2:0] INDEX_SEL, SRC_INDEX_SEL, SRC_WIDTH_LOG2, SRC_HSTRIDE, DST_INDEX_SEL, DST_HSTRIDE;
    logic [3:0] DST_COMP_MASK, STATUS_GROUPS;
    logic [5:0] SRC_VSTRIDE;
    logic [6:0] LOAD_REG;
    logic [11:0] INDEX_VALUE, SRC_ADDR, DST_ADDR;
    logic [15:0] DISPATCH_MASK, STATUS_MASK;
    logic [31:0] LOAD_BYTE_EN, SRC_IMM;
    logic [255:0] LOAD_DATA, SRC_DATA, DST_DATA;
    int n_errors = 0;
    int comparisons = 0;
    localparam logic [1:0] PR = srm_pkg::MODE_PAIRED;
    localparam logic [1:0] E8 = srm_pkg::MODE_EIGHT;
    localparam logic [1:0] S16 = srm_pkg::MODE_SIXTEEN;

    // 100 ns period
    always #50 CLOCK = ~CLOCK;

    srm_core #(.NUM_THREADS(4)) uut (.CLOCK, .RST, .DISPATCH_VALID, .DISPATCH_THREAD, .DISPATCH_MASK,
        .LOAD_VALID, .LOAD_THREAD, .LOAD_REG, .LOAD_BYTE_EN, .LOAD_DATA, .INDEX_WRITE, .INDEX_THREAD,
        .INDEX_SEL, .INDEX_VALUE, .SRC_VALID, .SRC_THREAD, .SRC_MODE, .SRC_SECOND_HALF, .SRC_FILE,
        .SRC_INDIRECT, .SRC_INDEX_SEL, .SRC_ADDR, .SRC_VSTRIDE, .SRC_WIDTH_LOG2, .SRC_HSTRIDE, .SRC_IMM,
        .SRC_DONE, .SRC_ERROR, .SRC_DATA, .DST_VALID, .DST_THREAD, .DST_MODE, .DST_SECOND_HALF,
        .DST_INDIRECT, .DST_INDEX_SEL, .DST_ADDR, .DST_HSTRIDE, .DST_COMP_MASK, .DST_DATA, .DST_DONE,
        .DST_ERROR, .STATUS_THREAD, .STATUS_MASK, .STATUS_GROUPS);

    srm_disp_model dm (.CLOCK, .DISPATCH_VALID, .DISPATCH_THREAD, .DISPATCH_MASK, .LOAD_VALID,
        .LOAD_THREAD, .LOAD_REG, .LOAD_BYTE_EN, .LOAD_DATA);

    // distinct word per register and dword
    function automatic logic [255:0] pat(input int r);
        for (int i = 0; i < 8; i++)
            pat[32*i+:32] = 32'hC000_0000 + 32'(r * 16 + i);
    endfunction

    function automatic logic [11:0] ad(input int r, input int s);
        return 12'(r * 32 + s);
    endfunction

    // dword select: set bit takes the new word
    function automatic logic [255:0] mix(input logic [255:0] n, input logic [255:0] o, input logic [7:0] en);
        for (int i = 0; i < 8; i++)
            mix[32*i+:32] = en[i] ? n[32*i+:32] : o[32*i+:32];
    endfunction

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [255:0] got, input logic [255:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t %s", $time, what);
        end
    endtask

    // source read; answer is due exactly one cycle after the request
    task automatic rd(input logic [1:0] th, input logic [1:0] md, input logic [11:0] a, input logic [5:0] vs,
        input logic [2:0] wl, input logic [2:0] hs, input logic e);
        @(posedge CLOCK);
        #1;
        SRC_VALID = 1'h1;
        {SRC_THREAD, SRC_MODE, SRC_ADDR, SRC_VSTRIDE, SRC_WIDTH_LOG2, SRC_HSTRIDE} = {th, md, a, vs, wl, hs};
        @(posedge CLOCK);
        #1;
        SRC_VALID = 1'h0;
        chk(SRC_DONE, 1, "read done");
        chk(SRC_ERROR, e, "read refusal");
        if (e)
            chk(SRC_DATA, 0, "refused read data");
    endtask

    task automatic wr(input logic [1:0] th, input logic [1:0] md, input logic sh, input logic [11:0] a,
        input logic [2:0] hs, input logic [3:0] cm, input logic [255:0] d, input logic e);
        @(posedge CLOCK);
        #1;
        DST_VALID = 1'h1;
        {DST_THREAD, DST_MODE, DST_SECOND_HALF, DST_ADDR, DST_HSTRIDE, DST_COMP_MASK} = {th, md, sh, a, hs, cm};
        DST_DATA = d;
        @(posedge CLOCK);
        #1;
        DST_VALID = 1'h0;
        chk(DST_DONE, 1, "write done");
        chk(DST_ERROR, e, "write refusal");
    endtask

    task automatic idx(input logic [1:0] th, input logic [2:0] sel, input logic [11:0] v);
        @(posedge CLOCK);
        #1;
        {INDEX_WRITE, INDEX_THREAD, INDEX_SEL, INDEX_VALUE} = {1'h1, th, sel, v};
        @(posedge CLOCK);
        #1;
        INDEX_WRITE = 1'h0;
    endtask

    // paired writes under one-flow and two-flow masks
    task automatic t_mask();
        logic [255:0] m = mix(pat(90), pat(4), 8'h07);
        STATUS_THREAD = 2'h0;
        dm.load(0, 4, '1, pat(4));
        dm.paired(0, 1'h0);
        chk(STATUS_MASK, 16'h000F, "one-flow mask");
        chk(STATUS_GROUPS, 4'h1, "one-flow groups");
        wr(0, PR, 0, ad(4, 0), 1, 4'h7, pat(90), 0);
        rd(0, E8, ad(4, 0), 8, 3, 1, 0);
        chk(SRC_DATA, m, "one-flow write");
        dm.paired(0, 1'h1);
        chk(STATUS_MASK, 16'h00FF, "two-flow mask");
        wr(0, PR, 0, ad(4, 0), 1, 4'h7, pat(91), 0);
        rd(0, E8, ad(4, 0), 8, 3, 1, 0);
        chk(SRC_DATA, mix(pat(91), m, 8'h77), "two-flow write");
        wr(0, PR, 0, ad(4, 0), 1, 4'h0, pat(93), 0);
        wr(0, srm_pkg::MODE_VEC4, 0, ad(4, 0), 1, 4'hB, pat(92), 0);
        rd(0, E8, ad(4, 0), 8, 3, 1, 0);
        chk(SRC_DATA, mix(pat(92), mix(pat(91), m, 8'h77), 8'h0B), "vec4 and empty mask write");
        rd(0, srm_pkg::MODE_VEC4, ad(4, 0), 8, 3, 1, 0);
        chk(SRC_DATA[255:128], 0, "vec4 upper channels zero");
        $display("test mask done");
    endtask

    // compressed halves under a subspan mask, indirect refused
    task automatic t_sixteen();
        STATUS_THREAD = 2'h1;
        dm.load(1, 10, '1, pat(10));
        dm.load(1, 11, '1, pat(11));
        dm.pixel(1, 4'h5);
        chk(STATUS_MASK, 16'h0F0F, "subspan mask");
        chk(STATUS_GROUPS, 4'h5, "subspan groups");
        wr(1, S16, 0, ad(10, 0), 1, 4'hF, pat(80), 0);
        wr(1, S16, 1, ad(10, 0), 1, 4'hF, pat(81), 0);
        DST_INDIRECT = 1'h1;
        wr(1, S16, 0, ad(10, 0), 1, 4'hF, pat(82), 1);
        DST_INDIRECT = 1'h0;
        rd(1, E8, ad(10, 0), 8, 3, 1, 0);
        chk(SRC_DATA, mix(pat(80), pat(10), 8'h0F), "first half");
        SRC_SECOND_HALF = 1'h1;
        rd(1, S16, ad(10, 0), 8, 3, 1, 0);
        chk(SRC_DATA, mix(pat(81), pat(11), 8'h0F), "second half");
        SRC_INDIRECT = 1'h1;
        rd(1, S16, ad(10, 0), 8, 3, 1, 1);
        {SRC_SECOND_HALF, SRC_INDIRECT} = 2'h0;
        $display("test sixteen done");
    endtask

    // shared vectors, replicated scalar, two-register window
    task automatic t_region();
        logic [255:0] p = pat(2);
        logic [255:0] q = pat(3);
        dm.load(0, 2, '1, p);
        dm.load(0, 3, '1, q);
        rd(0, PR, ad(2, 0), 0, 2, 1, 0);
        chk(SRC_DATA, {2{p[127:0]}}, "shared low vector");
        rd(0, PR, ad(2, 16), 0, 2, 1, 0);
        chk(SRC_DATA, {2{p[255:128]}}, "shared high vector");
        rd(0, PR, ad(2, 8), 0, 2, 1, 1);
        rd(0, E8, ad(2, 4), 0, 0, 0, 0);
        chk(SRC_DATA, {8{p[63:32]}}, "replicated scalar");
        rd(0, E8, ad(2, 4), 8, 3, 1, 0);
        chk(SRC_DATA, {q[31:0], p[255:32]}, "adjacent window");
        rd(0, E8, ad(2, 0), 8, 3, 3, 1);
        rd(0, E8, ad(2, 0), 16, 0, 0, 1);
        $display("test region done");
    endtask

    // refusals, file codes, indirect address
    task automatic t_refuse();
        dm.load(0, 5, '1, pat(5));
        wr(0, E8, 0, ad(5, 0), 2, 4'hF, pat(70), 1);
        wr(0, E8, 0, ad(5, 0), 4, 4'hF, pat(71), 1);
        rd(0, E8, ad(5, 0), 8, 3, 1, 0);
        chk(SRC_DATA, pat(5), "refused write kept");
        for (int f = 0; f < 4; f++)
        begin
            SRC_FILE = 2'(f);
            rd(0, E8, ad(5, 0), 8, 3, 1, f != 1 && f != 3);
            if (f == 3)
                chk(SRC_DATA, {8{SRC_IMM}}, "immediate operand");
        end
        SRC_FILE = 2'h1;
        idx(0, 2, ad(4, 0));
        {SRC_INDIRECT, SRC_INDEX_SEL} = {1'h1, 3'h2};
        rd(0, E8, 12'h020, 8, 3, 1, 0);
        chk(SRC_DATA, pat(5), "index plus offset");
        SRC_INDIRECT = 1'h0;
        $display("test refuse done");
    endtask

    // private contexts, wrap inside a thread, byte enables
    task automatic t_threads();
        logic [255:0] a = pat(20);
        logic [255:0] b = pat(21);
        dm.load(2, 0, '1, a);
        dm.load(2, 127, '1, b);
        dm.load(3, 127, '1, pat(31));
        dm.load(3, 127, 32'h0000_00F0, pat(32));
        rd(2, E8, ad(127, 4), 8, 3, 1, 0);
        chk(SRC_DATA, {a[31:0], b[255:32]}, "wrap in thread");
        rd(3, E8, ad(127, 0), 8, 3, 1, 0);
        chk(SRC_DATA, mix(pat(32), pat(31), 8'h02), "byte enables");
        wr(3, E8, 0, ad(127, 0), 1, 4'hF, pat(33), 0);
        rd(3, E8, ad(127, 0), 8, 3, 1, 0);
        chk(SRC_DATA, mix(pat(32), pat(31), 8'h02), "undispatched thread unwritten");
        $display("test threads done");
    endtask

    // hang guard
    initial
    begin
        repeat (5000) @(posedge CLOCK);
        n_errors++;
        $display("MISMATCH t=%0t run did not finish", $time);
        wrap_up();
    end

    initial
    begin
        {SRC_VALID, SRC_SECOND_HALF, SRC_INDIRECT, DST_VALID, DST_SECOND_HALF, DST_INDIRECT, INDEX_WRITE} = '0;
        {SRC_THREAD, SRC_MODE, DST_THREAD, DST_MODE, STATUS_THREAD, INDEX_THREAD} = '0;
        {INDEX_SEL, SRC_INDEX_SEL, SRC_WIDTH_LOG2, SRC_HSTRIDE, DST_INDEX_SEL, DST_HSTRIDE} = '0;
        {SRC_VSTRIDE, SRC_ADDR, DST_ADDR, INDEX_VALUE, DST_COMP_MASK, DST_DATA} = '0;
        SRC_FILE = 2'h1;
        SRC_IMM = 32'h1234_5678;
        repeat (20) @(posedge CLOCK);
        #1;
        chk(STATUS_MASK, 0, "reset mask");
        chk(SRC_DONE, 0, "reset done");
        RST = 1'h0;
        t_mask();
        t_sixteen();
        t_region();
        t_refuse();
        t_threads();
        wrap_up();
    end
endmodule

//--- tb/srm_disp_model.sv
// dispatcher and shared-function return path seen from the register file
module srm_disp_model (
    input wire logic CLOCK,
    output logic DISPATCH_VALID,
    output logic [1:0] DISPATCH_THREAD,
    output logic [15:0] DISPATCH_MASK,
    output logic LOAD_VALID,
    output logic [1:0] LOAD_THREAD,
    output logic [6:0] LOAD_REG,
    output logic [31:0] LOAD_BYTE_EN,
    output logic [255:0] LOAD_DATA
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle: strobes low, qualifiers hold junk
    initial
    begin
        {DISPATCH_VALID, LOAD_VALID} = 2'h0;
        {DISPATCH_THREAD, DISPATCH_MASK, LOAD_THREAD, LOAD_REG, LOAD_BYTE_EN} = '1;
        LOAD_DATA = '1;
    end

    // one pulse; released mask flips so a stale value is never trusted
    task automatic send(input logic [1:0] th, input logic [15:0] m);
        @(posedge CLOCK);
        #1;
        DISPATCH_VALID = 1'h1;
        DISPATCH_THREAD = th;
        DISPATCH_MASK = m;
        @(posedge CLOCK);
        #1;
        DISPATCH_VALID = 1'h0;
        DISPATCH_MASK = ~m;
    endtask

    task automatic paired(input logic [1:0] th, input logic both);
        send(th, both ? srm_pkg::MASK_PAIRED_BOTH : srm_pkg::MASK_PAIRED_ONE);
    endtask

    task automatic pixel(input logic [1:0] th, input logic [3:0] ok);
        logic [15:0] m;
        for (int g = 0; g < 4; g++)
            m[4*g+:4] = ok[g] ? 4'hF : 4'h0;
        send(th, m);
    endtask

    task automatic load(input logic [1:0] th, input logic [6:0] r, input logic [31:0] en, input logic [255:0] d);
        @(posedge CLOCK);
        #1;
        LOAD_VALID = 1'h1;
        LOAD_THREAD = th;
        LOAD_REG = r;
        LOAD_BYTE_EN = en;
        LOAD_DATA = d;
        @(posedge CLOCK);
        #1;
        LOAD_VALID = 1'h0;
        LOAD_DATA = ~d;
    endtask
endmodule
